// [rtl/updown_encoder_counter_core.v]
// 16-bit timer / encoder up-down counter with compare and capture registers, AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, and asynchronous encoder and capture pins.
`timescale 1ns/100ps
`default_nettype none
`include "counter_defines.vh"
module updown_encoder_counter_core #(
    parameter CW = 16,
    parameter PSW = 7
) (
    input wire aclk,
    input wire aresetn,
    input wire awvalid,
    output wire awready,
    input wire [`ADDR_W-1:0] awaddr,
    input wire [2:0] awprot,
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    input wire arvalid,
    output wire arready,
    input wire [`ADDR_W-1:0] araddr,
    input wire [2:0] arprot,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    input wire direction_or_down_input,
    input wire count_pulse_input,
    input wire external_clear_input,
    input wire capture_trigger_0,
    input wire capture_trigger_1,
    output reg timer_output_pin,
    output reg compare0_irq,
    output reg compare1_irq,
    output reg capcomp0_irq,
    output reg capcomp1_irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg [CW-1:0] count_q;
    reg [CW-1:0] cmp0_q;
    reg [CW-1:0] cmp1_q;
    reg [CW-1:0] cc0_q;
    reg [CW-1:0] cc1_q;
    reg [3:0] unit_mode_q;
    reg [3:0] timer_ctrl_q;
    reg [2:0] prescale_q;
    reg [1:0] cc_ctrl_q;
    reg [3:0] edge_sel_q;
    reg down_q;
    reg [PSW-1:0] ps_cnt_q;
    reg [4:0] pins_prev_q;

    // ------------------------------------------------------------
    // Bus write channel
    // ------------------------------------------------------------
    reg aw_held_q;
    reg w_held_q;
    reg [`ADDR_W-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    assign awready = ~aw_held_q & ~bvalid;
    assign wready = ~w_held_q & ~bvalid;
    wire wr_go = aw_held_q & w_held_q & ~bvalid;

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    wire [15:0] wr_val = merge16(16'h0000, w_data_q, w_strb_q);

    reg wr_hit;
    always @* begin
        case (aw_addr_q)
            `OFS_COUNT, `OFS_CMP0, `OFS_CMP1, `OFS_CC0, `OFS_CC1, `OFS_UNIT_MODE,
            `OFS_TIMER_CTRL, `OFS_PRESCALE, `OFS_CC_CTRL, `OFS_EDGE_SEL, `OFS_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= {`ADDR_W{1'b0}};
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    wire wr_count = wr_go & (aw_addr_q == `OFS_COUNT);

    // ------------------------------------------------------------
    // Mode decode and pin handling
    // ------------------------------------------------------------
    wire run = timer_ctrl_q[`TC_RUN];
    wire udc = unit_mode_q[`UM_CMD];
    wire mode_b = udc & unit_mode_q[`UM_MSEL];
    wire mode_a = udc & ~unit_mode_q[`UM_MSEL];
    wire [1:0] clr_sel = {timer_ctrl_q[`TC_CLR_HI], timer_ctrl_q[`TC_CLR_LO]};
    wire [4:0] pins_sync;

    pin_sync #(
        .WIDTH(5)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pins({capture_trigger_1, capture_trigger_0, external_clear_input,
               direction_or_down_input, count_pulse_input}),
        .pins_sync(pins_sync)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            pins_prev_q <= 5'h00;
        end else begin
            pins_prev_q <= pins_sync;
        end
    end

    wire enc_up;
    wire enc_down;

    encoder_decode u_dec (
        .enc_mode(unit_mode_q[`UM_ENC_HI:`UM_ENC_LO]),
        .pulse_cur(pins_sync[0]),
        .pulse_prev(pins_prev_q[0]),
        .dir_cur(pins_sync[1]),
        .dir_prev(pins_prev_q[1]),
        .up_evt(enc_up),
        .down_evt(enc_down)
    );

    wire [2:0] ps_sel = (prescale_q > `PS_MAX) ? `PS_MAX : prescale_q;
    wire [PSW-1:0] ps_mask = ~({PSW{1'b1}} << (ps_sel + 3'h1));
    wire ps_tick = ((ps_cnt_q & ps_mask) == ps_mask);

    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            ps_cnt_q <= {PSW{1'b0}};
        end else begin
            ps_cnt_q <= ps_cnt_q + {{(PSW-1){1'b0}}, 1'b1};
        end
    end

    // run gates events; timer counts up only
    wire up_evt = run & (udc ? enc_up : ps_tick);
    wire down_evt = run & udc & enc_down;

    wire match0 = (count_q == cmp0_q);
    wire match1 = (count_q == cmp1_q);
    wire ext_edge = pins_sync[2] & ~pins_prev_q[2];

    wire ext_clr_en = mode_a & ((clr_sel == `CLR_EXT) | (clr_sel == `CLR_BOTH));
    wire a_cm0_en = mode_a & ((clr_sel == `CLR_CM0) | (clr_sel == `CLR_BOTH));
    wire cm0_clr_en = udc ? (a_cm0_en | mode_b) : timer_ctrl_q[`TC_ENMD];
    wire ext_clr = run & ext_clr_en & ext_edge;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= `RST_16;
            down_q <= 1'b0;
        end else if (wr_count && !run) begin
            // write only when stopped, byte lanes
            count_q <= merge16(count_q, w_data_q, w_strb_q);
        end else if (ext_clr) begin
            count_q <= `RST_16;
        end else if (up_evt) begin
            down_q <= 1'b0;
            if (cm0_clr_en && match0) begin
                count_q <= `RST_16;
            end else begin
                count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end else if (down_evt) begin
            down_q <= 1'b1;
            if (mode_b && match1) begin
                count_q <= `RST_16;
            end else begin
                count_q <= count_q - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // ------------------------------------------------------------
    // Compare, capture and other registers
    // ------------------------------------------------------------
    // shared pins disable capture
    wire cap0_ok = run & ~cc_ctrl_q[`CCC_CMP0] & ~udc;
    wire cap1_ok = run & ~cc_ctrl_q[`CCC_CMP1] & ~ext_clr_en;
    wire cap0_edge = (edge_sel_q[`ES_CC0_LO] & pins_sync[3] & ~pins_prev_q[3]) |
                     (edge_sel_q[`ES_CC0_HI] & ~pins_sync[3] & pins_prev_q[3]);
    wire cap1_edge = (edge_sel_q[`ES_CC1_LO] & pins_sync[4] & ~pins_prev_q[4]) |
                     (edge_sel_q[`ES_CC1_HI] & ~pins_sync[4] & pins_prev_q[4]);
    wire cap0 = cap0_ok & cap0_edge;
    wire cap1 = cap1_ok & cap1_edge;
    wire cnt_evt = up_evt | down_evt;

    always @(posedge aclk) begin
        if (!aresetn) begin
            cmp0_q <= `RST_16;
            cmp1_q <= `RST_16;
            cc0_q <= `RST_16;
            cc1_q <= `RST_16;
            unit_mode_q <= 4'h0;
            timer_ctrl_q <= 4'h0;
            prescale_q <= 3'h0;
            cc_ctrl_q <= 2'h0;
            edge_sel_q <= 4'h0;
        end else begin
            if (wr_go) begin
                case (aw_addr_q)
                    `OFS_CMP0: cmp0_q <= merge16(cmp0_q, w_data_q, w_strb_q);
                    `OFS_CMP1: cmp1_q <= merge16(cmp1_q, w_data_q, w_strb_q);
                    `OFS_UNIT_MODE: if (w_strb_q[0]) unit_mode_q <= wr_val[3:0];
                    `OFS_TIMER_CTRL: if (w_strb_q[0]) timer_ctrl_q <= wr_val[3:0];
                    `OFS_PRESCALE: if (w_strb_q[0]) prescale_q <= wr_val[`PS_HI:`PS_LO];
                    `OFS_CC_CTRL: if (w_strb_q[0]) cc_ctrl_q <= wr_val[1:0];
                    `OFS_EDGE_SEL: if (w_strb_q[0]) edge_sel_q <= wr_val[3:0];
                    default: begin
                    end
                endcase
            end
            // Capture registers take software writes only in compare mode; a capture edge wins over a write.
            if (cap0) begin
                cc0_q <= count_q;
            end else if (wr_go && aw_addr_q == `OFS_CC0 && cc_ctrl_q[`CCC_CMP0]) begin
                cc0_q <= merge16(cc0_q, w_data_q, w_strb_q);
            end
            if (cap1) begin
                cc1_q <= count_q;
            end else if (wr_go && aw_addr_q == `OFS_CC1 && cc_ctrl_q[`CCC_CMP1]) begin
                cc1_q <= merge16(cc1_q, w_data_q, w_strb_q);
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pulses and timer output
    // ------------------------------------------------------------
    // Submode B only flags compare 0 and compare 1 matches seen while counting down.
    wire cmp_evt = mode_b ? down_evt : cnt_evt;

    always @(posedge aclk) begin
        if (!aresetn) begin
            compare0_irq <= 1'b0;
            compare1_irq <= 1'b0;
            capcomp0_irq <= 1'b0;
            capcomp1_irq <= 1'b0;
            timer_output_pin <= 1'b0;
        end else begin
            compare0_irq <= cmp_evt & match0;
            compare1_irq <= cmp_evt & match1;
            capcomp0_irq <= cc_ctrl_q[`CCC_CMP0] ? (cnt_evt & (count_q == cc0_q)) : cap0;
            capcomp1_irq <= cc_ctrl_q[`CCC_CMP1] ? (cnt_evt & (count_q == cc1_q)) : cap1;
            // PWM in timer mode with channel 0 in compare: high while running and the count is below the capture/compare 0 value.
            timer_output_pin <= run & ~udc & cc_ctrl_q[`CCC_CMP0] & (count_q < cc0_q);
        end
    end

    // ------------------------------------------------------------
    // Bus read channel
    // ------------------------------------------------------------
    reg [31:0] rd_mux;
    reg rd_hit;

    assign arready = ~rvalid;

    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (araddr)
            `OFS_COUNT: rd_mux[15:0] = count_q;
            `OFS_CMP0: rd_mux[15:0] = cmp0_q;
            `OFS_CMP1: rd_mux[15:0] = cmp1_q;
            `OFS_CC0: rd_mux[15:0] = cc0_q;
            `OFS_CC1: rd_mux[15:0] = cc1_q;
            `OFS_UNIT_MODE: rd_mux[3:0] = unit_mode_q;
            `OFS_TIMER_CTRL: rd_mux[3:0] = timer_ctrl_q;
            `OFS_PRESCALE: rd_mux[2:0] = prescale_q;
            `OFS_CC_CTRL: rd_mux[1:0] = cc_ctrl_q;
            `OFS_EDGE_SEL: rd_mux[3:0] = edge_sel_q;
            `OFS_STATUS: begin
                rd_mux[`ST_DOWN] = down_q;
                rd_mux[`ST_RUN] = run;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule // updown_encoder_counter_core
`default_nettype wire

// [rtl/counter_defines.vh]
// Constants of the 16-bit up/down encoder counter: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the core and the encoder decoder.
`ifndef COUNTER_DEFINES_VH
`define COUNTER_DEFINES_VH

`define ADDR_W 16
`define OFS_COUNT 16'hFF10
`define OFS_CMP0 16'hFF14
`define OFS_CMP1 16'hFF18
`define OFS_CC0 16'hFF1C
`define OFS_CC1 16'hFF20
`define OFS_UNIT_MODE 16'hFF24
`define OFS_TIMER_CTRL 16'hFF28
`define OFS_PRESCALE 16'hFF2C
`define OFS_CC_CTRL 16'hFF30
`define OFS_EDGE_SEL 16'hFF34
`define OFS_STATUS 16'hFF38

`define RST_16 16'h0000
`define RST_8 8'h00

// Unit mode register fields.
`define UM_CMD 0
`define UM_MSEL 1
`define UM_ENC_LO 2
`define UM_ENC_HI 3
// Timer control register fields.
`define TC_RUN 0
`define TC_ENMD 1
`define TC_CLR_LO 2
`define TC_CLR_HI 3
// Prescaler field.
`define PS_LO 0
`define PS_HI 2
`define PS_MAX 3'h6
// Capture/compare control: bit set selects compare mode.
`define CCC_CMP0 0
`define CCC_CMP1 1
// Edge select: per channel, low bit rising, high bit falling.
`define ES_CC0_LO 0
`define ES_CC0_HI 1
`define ES_CC1_LO 2
`define ES_CC1_HI 3
// Status fields.
`define ST_DOWN 0
`define ST_RUN 1

// Clear select encodings in submode A.
`define CLR_EXT 2'h0
`define CLR_CM0 2'h1
`define CLR_BOTH 2'h2
`define CLR_NONE 2'h3

// Encoder counting modes.
`define ENC_PULSE_DIR 2'h0
`define ENC_UP_DOWN 2'h1
`define ENC_PHASE_X1 2'h2
`define ENC_PHASE_X4 2'h3

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/pin_sync.v]
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is offered.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 5
) (
    input wire aclk,
    input wire aresetn,
    input wire [WIDTH-1:0] pins,
    output wire [WIDTH-1:0] pins_sync
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    assign pins_sync = sync_q;
endmodule // pin_sync
`default_nettype wire

// [rtl/encoder_decode.v]
// Turns the synchronised encoder pins into one-cycle up and down count events.
// Assumes inputs are already synchronised and the previous samples come from the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "counter_defines.vh"
module encoder_decode (
    input wire [1:0] enc_mode,
    input wire pulse_cur,
    input wire pulse_prev,
    input wire dir_cur,
    input wire dir_prev,
    output reg up_evt,
    output reg down_evt
);
    wire pulse_rise = pulse_cur & ~pulse_prev;
    wire dir_rise = dir_cur & ~dir_prev;
    wire x4_step = pulse_cur ^ pulse_prev ^ dir_cur ^ dir_prev;
    wire x4_down = pulse_prev ^ dir_cur;

    always @* begin
        up_evt = 1'b0;
        down_evt = 1'b0;
        case (enc_mode)
            `ENC_PULSE_DIR: begin
                up_evt = pulse_rise & ~dir_cur;
                down_evt = pulse_rise & dir_cur;
            end
            `ENC_UP_DOWN: begin
                // Coincident up and down pulses cancel out.
                up_evt = pulse_rise & ~dir_rise;
                down_evt = dir_rise & ~pulse_rise;
            end
            `ENC_PHASE_X1: begin
                up_evt = pulse_rise & ~dir_cur;
                down_evt = pulse_rise & dir_cur;
            end
            `ENC_PHASE_X4: begin
                up_evt = x4_step & ~x4_down;
                down_evt = x4_step & x4_down;
            end
            default: begin
                up_evt = 1'b0;
                down_evt = 1'b0;
            end
        endcase
    end
endmodule // encoder_decode
`default_nettype wire

// [test/counter_chk_sva.sv]
// Checker for the counter's register bus and compare event output.
// Assumes binding onto the top module; one clock, reset low.
`timescale 1ns/100ps
`default_nettype none
module counter_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic compare0_irq,
    input wire logic timer_output_pin
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_QUIET: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !compare0_irq && !timer_output_pin)
        else $error("busy after reset");
    AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("bvalid late");
    AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
        else $error("rvalid late");
    AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
        else $error("bvalid repeated");
    AST_BRESP_LEGAL: assert property (bvalid |-> bresp == 2'h0 || bresp == 2'h2)
        else $error("bad bresp");
    AST_NO_AR_BUSY: assert property (rvalid |-> !arready)
        else $error("ar taken while answering");
    AST_UPPER_ZERO: assert property (rvalid |-> rdata[31:16] == 16'h0000)
        else $error("rdata high half set");
    AST_SLVERR_ZERO: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0000_0000)
        else $error("data on error");
    AST_CM0_PULSE: assert property (compare0_irq |=> !compare0_irq)
        else $error("long compare pulse");
endmodule // counter_chk
`default_nettype wire

// [test/encoder_pins_model.sv]
// Encoder and trigger pins of the counter's far side.
// Assumes bench-called tasks; levels move after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module encoder_pins_model (
    input wire logic aclk,
    output logic direction_or_down_input,
    output logic count_pulse_input,
    output logic external_clear_input,
    output logic capture_trigger_0,
    output logic capture_trigger_1
);
    // Bit order: pulse, direction, clear, trigger 0, trigger 1.
    logic [4:0] pins_q = 5'h00;
    logic [1:0] phase_q = 2'h0;
    assign {capture_trigger_1, capture_trigger_0, external_clear_input} = pins_q[4:2];
    assign {direction_or_down_input, count_pulse_input} = pins_q[1:0];
    // Four cycles a level so the two-flop synchroniser never misses one.
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask
    task automatic pulse(input int idx);
        @(posedge aclk);
        pins_q[idx] <= 1'b1;
        settle();
        pins_q[idx] <= 1'b0;
        settle();
    endtask
    task automatic set_dir(input logic lvl);
        @(posedge aclk);
        pins_q[1] <= lvl;
        settle();
    endtask
    // Gray steps; the pulse pin leads when fwd is set.
    task automatic quad(input int n, input logic fwd);
        for (int i = 0; i < n; i++) begin
            @(posedge aclk);
            phase_q = fwd ? phase_q + 2'h1 : phase_q - 2'h1;
            pins_q[1:0] <= {phase_q[1], phase_q[1] ^ phase_q[0]};
            settle();
        end
    endtask
endmodule // encoder_pins_model
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the counter core.
// Assumes rtl/ on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "counter_defines.vh"
module tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [15:0] awaddr, araddr, v;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [2:0] prot = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, tout, cm0, cm1, cc0, cc1, pdir, ppul, pclr, pc0, pc1;
    logic [1:0] bresp, rresp, rs;
    int miscompares = 0, cmp_count = 0, cycles = 0, n0 = 0, n1 = 0, nc0 = 0, nc1 = 0, k, k1;
    always #20 aclk = ~aclk;
    updown_encoder_counter_core i_updown_encoder_counter_core (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(prot), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(prot), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .direction_or_down_input(pdir),
        .count_pulse_input(ppul), .external_clear_input(pclr), .capture_trigger_0(pc0),
        .capture_trigger_1(pc1), .timer_output_pin(tout), .compare0_irq(cm0), .compare1_irq(cm1),
        .capcomp0_irq(cc0), .capcomp1_irq(cc1));
    encoder_pins_model i_encoder_pins_model (.aclk(aclk), .direction_or_down_input(pdir),
        .count_pulse_input(ppul), .external_clear_input(pclr), .capture_trigger_0(pc0),
        .capture_trigger_1(pc1));
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        n0 <= n0 + (cm0 === 1'b1);
        n1 <= n1 + (cm1 === 1'b1);
        nc0 <= nc0 + (cc0 === 1'b1);
        nc1 <= nc1 + (cc1 === 1'b1);
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ----------
    // Bus and compare helpers
    // ----------
    task automatic check(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] inr(input logic [15:0] x, lo, hi);
        return {31'h0, x >= lo && x <= hi};
    endfunction
    task automatic axi_wr(input logic [15:0] a, d, input logic [3:0] s, output logic [1:0] r);
        logic b_t;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(posedge aclk);
            b_t = bvalid;
            r = bresp;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
    endtask
    task automatic axi_rd(input logic [15:0] a, output logic [15:0] d, output logic [1:0] r);
        logic r_t;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(posedge aclk);
            r_t = rvalid;
            d = rdata[15:0];
            r = rresp;
            if (arready) arvalid <= 1'b0;
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        axi_wr(a, d, 4'h3, rs);
        check(rs, `RESP_OKAY);
    endtask
    task automatic rd_count(output logic [15:0] d);
        axi_rd(`OFS_STATUS, d, rs);
        axi_rd(`OFS_COUNT, d, rs);
    endtask
    task automatic um(input logic [15:0] m, input logic [15:0] t, input logic [15:0] c);
        wr(`OFS_TIMER_CTRL, 16'h0000);
        wr(`OFS_UNIT_MODE, m);
        wr(`OFS_COUNT, c);
        wr(`OFS_TIMER_CTRL, t);
    endtask
    task automatic pulses(input int idx, input int n);
        repeat (n) i_encoder_pins_model.pulse(idx);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_basic();
        rd_count(v);
        check(v, `RST_16);
        wr(`OFS_COUNT, 16'h1234);
        axi_wr(`OFS_COUNT, 16'h00AB, 4'h1, rs);
        rd_count(v);
        check(v, 16'h12AB);
        prot <= 3'h5;
        axi_rd(16'hFF3C, v, rs);
        check(rs, `RESP_SLVERR);
        axi_wr(16'hFF3C, 16'h5A5A, 4'h3, rs);
        check(rs, `RESP_SLVERR);
    endtask
    // count clock 6.25 MHz at most
    task automatic t_prescale();
        for (int s = 1; s < 7; s++) begin
            wr(`OFS_TIMER_CTRL, 16'h0000);
            wr(`OFS_COUNT, 16'h0000);
            wr(`OFS_PRESCALE, 16'(s));
            wr(`OFS_TIMER_CTRL, 16'h0001);
            repeat (4 << (s + 1)) @(posedge aclk);
            wr(`OFS_TIMER_CTRL, 16'h0000);
            rd_count(v);
            check(v, 16'h0004);
        end
    endtask
    task automatic t_gpclear();
        wr(`OFS_PRESCALE, 16'h0001);
        wr(`OFS_COUNT, 16'h0000);
        wr(`OFS_CMP0, 16'h0003);
        k = n0;
        wr(`OFS_TIMER_CTRL, 16'h0001);
        wr(`OFS_COUNT, 16'h5555);
        repeat (60) @(posedge aclk);
        wr(`OFS_TIMER_CTRL, 16'h0000);
        rd_count(v);
        check(inr(v, 16'h0004, 16'h0100), 32'h1);
        check(n0 - k, 1);
        wr(`OFS_COUNT, 16'h0000);
        k = n0;
        wr(`OFS_TIMER_CTRL, 16'h0003);
        repeat (30) @(posedge aclk);
        wr(`OFS_TIMER_CTRL, 16'h0003);
        wr(`OFS_CMP0, 16'h0003);
        repeat (30) @(posedge aclk);
        wr(`OFS_TIMER_CTRL, 16'h0000);
        rd_count(v);
        check(inr(v, 16'h0000, 16'h0003), 32'h1);
        check(inr(16'(n0 - k), 16'h0003, 16'h0008), 32'h1);
    endtask
    task automatic t_capture();
        wr(`OFS_CC_CTRL, 16'h0001);
        wr(`OFS_CC0, 16'h0200);
        wr(`OFS_EDGE_SEL, 16'h0005);
        wr(`OFS_COUNT, 16'h0100);
        wr(`OFS_TIMER_CTRL, 16'h0001);
        k = nc1;
        i_encoder_pins_model.pulse(4);
        check(tout, 1'b1);
        wr(`OFS_TIMER_CTRL, 16'h0000);
        wr(`OFS_CC_CTRL, 16'h0000);
        check(nc1 - k, 1);
        axi_rd(`OFS_CC1, v, rs);
        check(inr(v, 16'h0100, 16'h01FF), 32'h1);
        wr(`OFS_UNIT_MODE, 16'h0001);
        wr(`OFS_TIMER_CTRL, 16'h0001);
        k = nc0 + nc1;
        i_encoder_pins_model.pulse(3);
        i_encoder_pins_model.pulse(4);
        check(nc0 + nc1 - k, 0);
        axi_rd(`OFS_CC0, v, rs);
        check(v, 16'h0200);
    endtask
    task automatic t_modes();
        um(16'h0001, 16'h000D, 16'h0001);
        pulses(0, 2);
        i_encoder_pins_model.set_dir(1'b1);
        pulses(0, 4);
        rd_count(v);
        check(v, 16'hFFFF);
        i_encoder_pins_model.set_dir(1'b0);
        um(16'h0005, 16'h000D, 16'h0002);
        pulses(0, 1);
        pulses(1, 4);
        rd_count(v);
        check(v, 16'hFFFF);
        um(16'h0009, 16'h000D, 16'h0004);
        i_encoder_pins_model.quad(8, 1'b1);
        rd_count(v);
        check(v, 16'h0006);
        i_encoder_pins_model.quad(8, 1'b0);
        rd_count(v);
        check(v, 16'h0004);
        um(16'h000D, 16'h000D, 16'h0008);
        i_encoder_pins_model.quad(8, 1'b1);
        rd_count(v);
        check(v, 16'h0010);
        i_encoder_pins_model.quad(8, 1'b0);
        rd_count(v);
        check(v, 16'h0008);
    endtask
    task automatic t_subb();
        wr(`OFS_CMP0, 16'h0002);
        wr(`OFS_CMP1, 16'h0005);
        um(16'h0003, 16'h000D, 16'h0000);
        k = n0;
        pulses(0, 3);
        rd_count(v);
        check(v, 16'h0000);
        check(n0 - k, 0);
        um(16'h0003, 16'h000D, 16'h0007);
        k1 = n1;
        i_encoder_pins_model.set_dir(1'b1);
        pulses(0, 3);
        rd_count(v);
        check(v, 16'h0000);
        check(n1 - k1, 1);
        i_encoder_pins_model.set_dir(1'b0);
    endtask
    task automatic t_suba();
        logic [15:0] bef [4] = '{16'h000E, 16'h0002, 16'h0002, 16'h000E};
        logic [15:0] aft [4] = '{16'h0000, 16'h0002, 16'h0000, 16'h000E};
        wr(`OFS_CMP0, 16'h000B);
        for (int s = 0; s < 4; s++) begin
            um(16'h0001, 16'(s * 4 + 1), 16'h000A);
            pulses(0, 4);
            rd_count(v);
            check(v, bef[s]);
            i_encoder_pins_model.pulse(2);
            rd_count(v);
            check(v, aft[s]);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_basic();
        t_prescale();
        t_gpclear();
        t_capture();
        t_modes();
        t_subb();
        t_suba();
        report_and_stop();
    end
endmodule // tb
bind updown_encoder_counter_core counter_chk i_counter_chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .rdata(rdata), .rresp(rresp), .compare0_irq(compare0_irq), .timer_output_pin(timer_output_pin));
`default_nettype wire
